// ---- common/idp_pkg.sv ----
// Shared constants and types for the initiator data phase control pair.
package idp_pkg;

    // ************************************************************
    // Register map of the application end, byte addresses.
    // ************************************************************
    localparam int        AXI_ADDR_W      = 4;
    localparam logic [3:0] CTRL_OFFSET     = 4'h0;
    localparam logic [3:0] BURST_OFFSET    = 4'h4;
    localparam logic [3:0] STATUS_OFFSET   = 4'h8;

    localparam int CTRL_START_BIT   = 0;
    localparam int CTRL_READY_BIT   = 1;
    localparam int STATUS_BUSY_BIT  = 0;
    localparam int STATUS_WAIT_BIT  = 1;
    localparam int STATUS_DONE_BIT  = 2;
    localparam int STATUS_STOP_BIT  = 3;
    localparam int STATUS_COUNT_LSB = 4;

    localparam logic        READY_FLAG_RESET = 1'b1;
    localparam logic [3:0]  BURST_RESET      = 4'h1;
    localparam logic [1:0]  RESP_OKAY        = 2'b00;
    localparam logic [1:0]  RESP_SLVERR      = 2'b10;

    // ************************************************************
    // Transfer counter and finish thresholds.
    // ************************************************************
    localparam logic [3:0] COUNT_RESET = 4'h0;
    localparam logic [3:0] COUNT_STEP  = 4'h1;
    localparam logic [3:0] LEFT_ONE    = 4'h1;
    localparam logic [3:0] LEFT_TWO    = 4'h2;
    localparam logic [3:0] LEFT_THREE  = 4'h3;

    // Longest wait for the first data phase after frame, in clocks.
    localparam int FIRST_PHASE_LIMIT = 8;

    typedef enum logic [1:0]
    {
        IDP_DEV_IDLE = 2'b00,
        IDP_DEV_ADDR = 2'b01,
        IDP_DEV_DATA = 2'b10
    } idp_dev_state_type;

    typedef enum logic [1:0]
    {
        IDP_APP_IDLE = 2'b00,
        IDP_APP_REQ  = 2'b01,
        IDP_APP_XFER = 2'b10,
        IDP_APP_DONE = 2'b11
    } idp_app_state_type;

endpackage

// ---- common/idp_ctrl_if.sv ----
// Interface joining the application end and the initiator end.
`timescale 1ns/10ps
interface idp_ctrl_if;
    logic request;
    logic initiator_ready;
    logic complete;
    logic data_state;
    logic data_state_flag_delayed;
    logic transfer_valid;
    logic data_state_ended;

    modport initiator
    (
        input  request,
        input  initiator_ready,
        input  complete,
        output data_state,
        output data_state_flag_delayed,
        output transfer_valid,
        output data_state_ended
    );

    modport application
    (
        output request,
        output initiator_ready,
        output complete,
        input  data_state,
        input  data_state_flag_delayed,
        input  transfer_valid,
        input  data_state_ended
    );
endinterface

// ---- verilog/idp_transfer_counter.sv ----
// Remaining-transfer counter of the application end.
`timescale 1ns/10ps
module idp_transfer_counter
#(
    parameter int COUNT_W = 4
)
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic               load,
    input  wire logic [COUNT_W-1:0] length,
    input  wire logic               step,
    output logic      [COUNT_W-1:0] count
);
    // The finish thresholds compare against three, which two bits can still hold.
    if (COUNT_W < 2 || COUNT_W > 4)
    begin : width_check
        $error("COUNT_W must lie between 2 and 4");
    end

    wire [COUNT_W-1:0] count_less = count - COUNT_W'(idp_pkg::COUNT_STEP);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            count <= COUNT_W'(idp_pkg::COUNT_RESET); // R17
        else if (load)
            count <= length; // R17
        else if (step)
            count <= count_less; // R17
    end
endmodule

// ---- verilog/idp_initiator_end.sv ----
// Initiator end: turns the two control levels into bus ready and frame.
`timescale 1ns/10ps
module idp_initiator_end
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    idp_ctrl_if.initiator     ctrl,
    input  wire logic         target_ready_pin,
    input  wire logic         target_stop_pin,
    output logic              bus_initiator_ready_line,
    output logic              bus_frame_line
);
    idp_pkg::idp_dev_state_type state;
    idp_pkg::idp_dev_state_type next_state;

    logic [1:0] trdy_sync;
    logic [1:0] stop_sync;
    logic       first_done;
    logic       data_q;
    logic       ended;
    logic       valid_q;

    wire target_ready = trdy_sync[1];
    wire target_stop  = stop_sync[1];
    wire in_data      = (state == idp_pkg::IDP_DEV_DATA);
    wire phase_done   = in_data & !bus_initiator_ready_line & target_ready; // R17
    wire last_done    = phase_done & bus_frame_line; // R4
    // A target stop ends the transaction no matter what the mode asks for.
    wire target_end   = in_data & target_stop; // R7
    wire leaving      = last_done | target_end;
    // Wait modes may hold only the first data phase; later phases always proceed.
    wire ready_level  = ctrl.initiator_ready | first_done; // R6

    assign ctrl.transfer_valid          = valid_q;
    assign ctrl.data_state              = in_data;
    assign ctrl.data_state_flag_delayed = data_q;
    assign ctrl.data_state_ended        = ended;

    always_comb
    begin
        next_state = state;
        case (state)
            idp_pkg::IDP_DEV_IDLE: if (ctrl.request) next_state = idp_pkg::IDP_DEV_ADDR;
            idp_pkg::IDP_DEV_ADDR: next_state = idp_pkg::IDP_DEV_DATA;
            idp_pkg::IDP_DEV_DATA: if (leaving) next_state = idp_pkg::IDP_DEV_IDLE;
            default:               next_state = idp_pkg::IDP_DEV_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            trdy_sync <= 2'b00;
            stop_sync <= 2'b00;
        end
        else
        begin
            trdy_sync <= {trdy_sync[0], target_ready_pin};
            stop_sync <= {stop_sync[0], target_stop_pin};
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state      <= idp_pkg::IDP_DEV_IDLE;
            data_q     <= 1'b0;
            ended      <= 1'b0;
            first_done <= 1'b0;
            valid_q    <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            data_q     <= in_data;
            ended      <= in_data & leaving; // R12
            first_done <= in_data & !leaving & (first_done | phase_done);
            valid_q    <= phase_done; // R17
        end
    end

    // Lines idle high; they take the controls seen one edge earlier.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bus_initiator_ready_line <= 1'b1;
            bus_frame_line           <= 1'b1;
        end
        else if (state == idp_pkg::IDP_DEV_IDLE)
        begin
            bus_initiator_ready_line <= 1'b1;
            bus_frame_line           <= !ctrl.request;
        end
        else if (leaving)
        begin
            bus_initiator_ready_line <= 1'b1;
            bus_frame_line           <= 1'b1;
        end
        else
        begin
            bus_initiator_ready_line <= !(in_data & ready_level); // R1 R2 R3 R4 R9
            // Once frame is released it stays released until the end.
            bus_frame_line <= ctrl.complete | (in_data & bus_frame_line); // R1 R2 R3 R4 R9
        end
    end
endmodule

// ---- verilog/idp_application_end.sv ----
// Application end: AXI4-Lite registers, request sequencing and mode control.
//
// Function
// R1: Wait burst holds ready off, frame on.
// R2: Wait single holds ready off, frame off.
// R3: Proceed asserts ready, frame on, full rate.
// R4: Finish asserts ready, releases frame, ends.
// R5: Modes change only along permitted sequences.
// R6: Wait modes delay only first data phase.
// R7: Sequencing lapses after uncontrolled termination.
// R8: First data phase within 8 clocks; not enforced, the ready flag alone sets the wait.
// R9: Controls lead their effect by one cycle.
// R10: Valid mode one cycle after request.
// R11: Finish held until transaction ends.
// R12: Falling data state releases held finish.
// R13: Single word: wait single or finish early.
// R14: Two words start wait burst or proceed.
// R15: Two words: finish after proceed and data.
// R16: Bursts finish at three left with valid.
// R17: Counter loads length, decrements per transfer.
// R18: Ready tracker resamples and records waiting.
// R19: Finish trigger from one, two, three left.
// R20: Complete is trigger or hold flag.
// R21: Controls never tied to constants.
// R22: Request only when ready, shallow logic.
// R23: Request lasts exactly one clock.
`timescale 1ns/10ps
module idp_application_end
#(
    parameter int COUNT_W = 4
)
(
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    idp_ctrl_if.application           ctrl,
    input  wire logic [3:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [3:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready
);
    if (COUNT_W != 4)
    begin : width_check
        $error("COUNT_W must be 4 to match the burst register");
    end

    idp_pkg::idp_app_state_type state;
    idp_pkg::idp_app_state_type next_state;

    logic [3:0]         aw_addr;
    logic               aw_held;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               w_held;
    logic               ready_flag;
    logic [3:0]         burst_length;
    logic               start;
    logic               done_flag;
    logic               stop_flag;
    logic               init_ready;
    logic               waited_last_cycle;
    logic               hold_complete;
    logic [COUNT_W-1:0] transfers_left_count;

    // ************************************************************
    // AXI4-Lite slave.
    // ************************************************************
    wire do_write  = aw_held & w_held & !s_axi_bvalid;
    wire wr_ctrl   = do_write & (aw_addr == idp_pkg::CTRL_OFFSET);
    wire wr_burst  = do_write & (aw_addr == idp_pkg::BURST_OFFSET);
    wire wr_status = do_write & (aw_addr == idp_pkg::STATUS_OFFSET);
    wire wr_hit    = wr_ctrl | wr_burst | wr_status;
    wire do_read   = s_axi_arvalid & s_axi_arready;
    wire busy      = (state != idp_pkg::IDP_APP_IDLE);
    // A start while a transfer is under way is dropped.
    wire start_req = wr_ctrl & w_strb[0] & w_data[idp_pkg::CTRL_START_BIT] & !busy;

    wire [31:0] ctrl_word   = 32'(ready_flag) << idp_pkg::CTRL_READY_BIT;
    wire [31:0] burst_word  = {28'h000_0000, burst_length};
    wire [31:0] status_word = (32'(busy) << idp_pkg::STATUS_BUSY_BIT)
                            | (32'(waited_last_cycle) << idp_pkg::STATUS_WAIT_BIT)
                            | (32'(done_flag) << idp_pkg::STATUS_DONE_BIT)
                            | (32'(stop_flag) << idp_pkg::STATUS_STOP_BIT)
                            | (32'(transfers_left_count) << idp_pkg::STATUS_COUNT_LSB);
    wire rd_ctrl   = (s_axi_araddr == idp_pkg::CTRL_OFFSET);
    wire rd_burst  = (s_axi_araddr == idp_pkg::BURST_OFFSET);
    wire rd_status = (s_axi_araddr == idp_pkg::STATUS_OFFSET);
    wire rd_hit    = rd_ctrl | rd_burst | rd_status;
    wire [31:0] rd_word = rd_ctrl ? ctrl_word : rd_burst ? burst_word
                        : rd_status ? status_word : 32'h0000_0000;

    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 4'h0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= idp_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid & !aw_held)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (do_write)
                aw_held <= 1'b0;
            if (s_axi_wvalid & !w_held)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (do_write)
                w_held <= 1'b0;
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? idp_pkg::RESP_OKAY : idp_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= idp_pkg::RESP_OKAY;
        end
        else if (do_read)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? idp_pkg::RESP_OKAY : idp_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Done and stop flags: hardware set wins over a write-one clear.
    wire clr_done = wr_status & w_strb[0] & w_data[idp_pkg::STATUS_DONE_BIT];
    wire clr_stop = wr_status & w_strb[0] & w_data[idp_pkg::STATUS_STOP_BIT];
    wire ended_short = ctrl.data_state_ended & (transfers_left_count != COUNT_W'(ctrl.transfer_valid));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ready_flag   <= idp_pkg::READY_FLAG_RESET;
            burst_length <= idp_pkg::BURST_RESET;
            start        <= 1'b0;
            done_flag    <= 1'b0;
            stop_flag    <= 1'b0;
        end
        else
        begin
            if (wr_ctrl & w_strb[0])
                ready_flag <= w_data[idp_pkg::CTRL_READY_BIT];
            if (wr_burst & w_strb[0])
                burst_length <= w_data[3:0];
            start     <= start_req;
            done_flag <= ctrl.data_state_ended | (done_flag & !clr_done);
            // A transaction cut short by the target leaves transfers behind.
            stop_flag <= ended_short | (stop_flag & !clr_stop); // R7
        end
    end

    // ************************************************************
    // Request sequencing.
    // ************************************************************
    always_comb
    begin
        next_state = state;
        case (state)
            idp_pkg::IDP_APP_IDLE: if (start) next_state = idp_pkg::IDP_APP_REQ;
            idp_pkg::IDP_APP_REQ:  next_state = idp_pkg::IDP_APP_XFER;
            idp_pkg::IDP_APP_XFER: if (ctrl.data_state_ended) next_state = idp_pkg::IDP_APP_DONE;
            idp_pkg::IDP_APP_DONE: next_state = idp_pkg::IDP_APP_IDLE;
            default:               next_state = idp_pkg::IDP_APP_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state <= idp_pkg::IDP_APP_IDLE;
        else
            state <= next_state;
    end

    // The request comes a cycle after start, once the tracker has sampled readiness.
    assign ctrl.request = (state == idp_pkg::IDP_APP_REQ); // R23 R22

    idp_transfer_counter #(.COUNT_W(COUNT_W)) counter
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .load    (start),
        .length  (burst_length),
        .step    (ctrl.transfer_valid),
        .count   (transfers_left_count)
    );

    // ************************************************************
    // Mode control.
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            init_ready        <= 1'b1; // R18
            waited_last_cycle <= 1'b0; // R18
        end
        else
        begin
            waited_last_cycle <= !init_ready; // R18
            if (start | !init_ready)
                init_ready <= ready_flag; // R18
        end
    end

    wire one_transfer_left    = (transfers_left_count == COUNT_W'(idp_pkg::LEFT_ONE));
    wire two_transfers_left   = (transfers_left_count == COUNT_W'(idp_pkg::LEFT_TWO));
    wire three_transfers_left = (transfers_left_count == COUNT_W'(idp_pkg::LEFT_THREE));

    // Single word: finish is chosen together with the request.
    wire finish_one_left   = one_transfer_left & ctrl.request; // R10 R13 R19
    // Two words: finish after proceed and one data cycle, unless we waited.
    wire finish_two_left   = two_transfers_left & ctrl.data_state_flag_delayed
                           & !waited_last_cycle; // R14 R15 R19
    wire finish_three_left = three_transfers_left & ctrl.transfer_valid; // R16 R19
    wire assert_complete   = finish_one_left | finish_two_left | finish_three_left; // R19

    // Holding finish until the data state falls keeps the mode steady to the end.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            hold_complete <= 1'b0; // R20
        else if (ctrl.data_state_ended)
            hold_complete <= 1'b0; // R12 R20
        else if (assert_complete)
            hold_complete <= 1'b1; // R11 R20
    end

    // Both levels come from live logic; the tracker alone may delay the first phase,
    // and the user must keep that delay under the first-phase limit.
    assign ctrl.complete        = assert_complete | hold_complete; // R20 R21 R5
    assign ctrl.initiator_ready = init_ready; // R18 R21 R6 R8
endmodule

// ---- tb/idp_properties.sv ----
// Concurrent checks on the control link between the application and initiator ends.
`timescale 1ns/10ps
module idp_properties
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic request,
    input wire logic initiator_ready,
    input wire logic complete,
    input wire logic data_state,
    input wire logic data_state_flag_delayed,
    input wire logic transfer_valid,
    input wire logic data_state_ended,
    input wire logic bus_initiator_ready_line,
    input wire logic bus_frame_line
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ******************************
    // Link properties
    // ******************************
    sequence s_launch;
        !bus_frame_line ##1 data_state;
    endsequence

    sequence s_wind_down;
        data_state_ended && bus_initiator_ready_line && bus_frame_line;
    endsequence

    a_request_pulse: assert property (request |=> !request)
        else $error("request lasted more than one cycle");
    a_request_launch: assert property (request |=> s_launch)
        else $error("frame or data state late after request");
    a_wait_burst: assert property (data_state && !initiator_ready && !complete
        |=> bus_initiator_ready_line && !bus_frame_line)
        else $error("wait burst lines wrong");
    a_wait_single: assert property (data_state && !initiator_ready && complete
        |=> bus_initiator_ready_line && bus_frame_line)
        else $error("wait single lines wrong");
    a_proceed_lines: assert property (data_state && initiator_ready && !complete
        && !transfer_valid |=> !bus_initiator_ready_line && !bus_frame_line)
        else $error("proceed lines wrong");
    a_finish_lines: assert property (data_state && initiator_ready && complete
        && !transfer_valid |=> data_state_ended || (!bus_initiator_ready_line && bus_frame_line))
        else $error("finish lines wrong");
    a_valid_phase: assert property (transfer_valid |->
        data_state_flag_delayed && !$past(bus_initiator_ready_line))
        else $error("transfer valid outside a ready data phase");
    a_finish_held: assert property (data_state && complete |=> complete || !data_state)
        else $error("finish released inside the data state");
    a_data_end: assert property ($fell(data_state) |-> s_wind_down)
        else $error("end of data state not marked");
    a_ended_pulse: assert property (data_state_ended |->
        data_state_flag_delayed ##1 !data_state_ended)
        else $error("data state end pulse malformed");
endmodule

// ---- tb/tb_initiator_data_phase_control.sv ----
// Self-checking bench for the two ends joined back to back over the control link.
`timescale 1ns/10ps
module tb_initiator_data_phase_control;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  awaddr = 4'h0;
    logic        awvalid = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic [3:0]  araddr = 4'h0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        trdy = 1'b1;
    logic        stop = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irdy_line, frame_line;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          err_count = 0;
    int          n_compared = 0;
    int          n_valid = 0;
    int          n_base = 0;
    int          cycles = 0;
    int          lens [5] = '{1, 2, 3, 4, 15};

    idp_ctrl_if ctrl_if ();

    always #25 aclk = ~aclk;

    idp_application_end idp_application_end_inst
    (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .ctrl          (ctrl_if.application),
        .s_axi_awaddr  (awaddr),
        .s_axi_awvalid (awvalid),
        .s_axi_awready (awready),
        .s_axi_wdata   (wdata),
        .s_axi_wstrb   (4'hf),
        .s_axi_wvalid  (wvalid),
        .s_axi_wready  (wready),
        .s_axi_bresp   (bresp),
        .s_axi_bvalid  (bvalid),
        .s_axi_bready  (bready),
        .s_axi_araddr  (araddr),
        .s_axi_arvalid (arvalid),
        .s_axi_arready (arready),
        .s_axi_rdata   (rdata),
        .s_axi_rresp   (rresp),
        .s_axi_rvalid  (rvalid),
        .s_axi_rready  (rready)
    );

    idp_initiator_end idp_initiator_end_inst
    (
        .aclk                     (aclk),
        .aresetn                  (aresetn),
        .ctrl                     (ctrl_if.initiator),
        .target_ready_pin         (trdy),
        .target_stop_pin          (stop),
        .bus_initiator_ready_line (irdy_line),
        .bus_frame_line           (frame_line)
    );

    idp_properties idp_properties_inst
    (
        .aclk                     (aclk),
        .aresetn                  (aresetn),
        .request                  (ctrl_if.request),
        .initiator_ready          (ctrl_if.initiator_ready),
        .complete                 (ctrl_if.complete),
        .data_state               (ctrl_if.data_state),
        .data_state_flag_delayed  (ctrl_if.data_state_flag_delayed),
        .transfer_valid           (ctrl_if.transfer_valid),
        .data_state_ended         (ctrl_if.data_state_ended),
        .bus_initiator_ready_line (irdy_line),
        .bus_frame_line           (frame_line)
    );

    // ******************************
    // Bus tasks
    // ******************************
    task automatic end_of_test;
        $display("compared %0d mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // A hang in any handshake wait ends here rather than running forever.
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (ctrl_if.transfer_valid === 1'b1)
            n_valid <= n_valid + 1;
        if (cycles == 20000)
        begin
            err_count++;
            end_of_test();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        check("write response", {30'h0, r}, {30'h0, idp_pkg::RESP_OKAY});
    endtask

    task automatic rd_check(input logic [3:0] a, input logic [31:0] exp, input string name);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        check(name, d, exp);
        check("read response", {30'h0, r}, {30'h0, idp_pkg::RESP_OKAY});
    endtask

    // ******************************
    // Scenarios
    // ******************************
    task automatic start(input logic [3:0] len, input logic rflag);
        n_base = n_valid;
        wr(idp_pkg::BURST_OFFSET, {28'h0, len});
        wr(idp_pkg::CTRL_OFFSET, {30'h0, rflag, 1'b1});
    endtask

    task automatic wait_data;
        while (ctrl_if.data_state !== 1'b1)
            @(posedge aclk);
        @(posedge aclk);
    endtask

    task automatic finish(input int exp_n, input logic [31:0] exp_status);
        logic [31:0] s;
        logic [1:0]  r;
        s = 32'h0000_0000;
        while ((s & 32'h0000_0005) !== 32'h0000_0004)
            axi_read(idp_pkg::STATUS_OFFSET, s, r);
        check("data phases", n_valid - n_base, exp_n);
        check("status at end", s, exp_status);
        wr(idp_pkg::STATUS_OFFSET, 32'h0000_000c);
        rd_check(idp_pkg::STATUS_OFFSET, exp_status & 32'hffff_fff3, "status cleared");
    endtask

    initial
    begin
        logic [31:0] s;
        logic [1:0]  r;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        check("idle lines", {30'h0, irdy_line, frame_line}, 32'h0000_0003);
        rd_check(idp_pkg::CTRL_OFFSET, 32'h0000_0002, "control reset");
        rd_check(idp_pkg::BURST_OFFSET, 32'h0000_0001, "burst reset");
        rd_check(idp_pkg::STATUS_OFFSET, 32'h0000_0000, "status reset");
        axi_write(4'hc, 32'hffff_ffff, r);
        check("unmapped write", {30'h0, r}, {30'h0, idp_pkg::RESP_SLVERR});
        axi_read(4'hc, s, r);
        check("unmapped data", s, 32'h0000_0000);
        check("unmapped read", {30'h0, r}, {30'h0, idp_pkg::RESP_SLVERR});
        foreach (lens[i])
        begin
            start(lens[i][3:0], 1'b1);
            finish(lens[i], 32'h0000_0004);
        end
        start(4'h1, 1'b0);
        wait_data();
        check("wait single lines", {30'h0, irdy_line, frame_line}, 32'h0000_0003);
        wr(idp_pkg::CTRL_OFFSET, 32'h0000_0002);
        finish(1, 32'h0000_0004);
        start(4'h2, 1'b0);
        wait_data();
        check("wait burst lines", {30'h0, irdy_line, frame_line}, 32'h0000_0002);
        wr(idp_pkg::CTRL_OFFSET, 32'h0000_0002);
        finish(2, 32'h0000_0004);
        trdy <= 1'b0;
        start(4'h3, 1'b1);
        wait_data();
        repeat (3) @(posedge aclk);
        check("proceed lines", {30'h0, irdy_line, frame_line}, 32'h0000_0000);
        trdy <= 1'b1;
        finish(3, 32'h0000_0004);
        trdy <= 1'b0;
        start(4'h1, 1'b0);
        wait_data();
        stop <= 1'b1;
        while (ctrl_if.data_state_ended !== 1'b1)
            @(posedge aclk);
        stop <= 1'b0;
        trdy <= 1'b1;
        wr(idp_pkg::CTRL_OFFSET, 32'h0000_0002);
        finish(0, 32'h0000_001c);
        end_of_test();
    end
endmodule
